/* File: design/cie_ctrl.sv */
// interrupt flags, enables and error counters of a CAN controller
// assumes the protocol engine drives event pulses, error levels and counters
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

// How it works
// R1: status bit 13 high while transmitter is bus off.
// R2: status bit 12 high while transmitter is error passive.
// R3: status bit 11 high while receiver is error passive.
// R4: status bit 10 high while transmitter is in warning.
// R5: status bit 9 high while receiver is in warning.
// R6: status bit 8 high when either side is in warning.
// R7: error flag bit 5 set when any error state bit 13:8 rises.
// R8: bad message event sets flag bit 7.
// R9: bus wake-up activity sets flag bit 6.
// R10: queue almost full event sets flag bit 3.
// R11: receive overflow sets flag bit 2.
// R12: receive buffer sets bit 1, transmit buffer sets bit 0.
// R13: seven enable bits at same positions, readable and writable, zero at reset.
// R14: bit 4, flag bits 15:14 and enable upper byte read zero.
// R15: transmit error counter reads in bits 15:8 of count register.
// R16: receive error counter reads in bits 7:0 of count register.
// R17: flags stick until written one; a set in the clear cycle wins.
// R18: interrupt high while any flag and its enable are both set.
// R19: error state bits are read-only and follow the live state.
module cie_ctrl
    import cie_pkg::*;
(
    // clock and reset
    input  wire logic                   i_clock,
    input  wire logic                   i_rstn,
    // register port
    input  wire logic [CIE_ADDR_W-1:0]  i_addr,
    input  wire logic [15:0]            i_wdata,
    input  wire logic                   i_wr,
    input  wire logic                   i_rd,
    output logic      [15:0]            o_rdata,
    // protocol engine side
    input  wire cie_pkg::cie_events_t   i_events,
    input  wire cie_pkg::cie_err_state_t i_err_state,
    input  wire logic [7:0]             i_tx_error_counter,
    input  wire logic [7:0]             i_rx_error_counter,
    // interrupt
    output logic                        o_irq
);
    import cie_pkg::*;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    logic wr_flags_hit;
    logic wr_enables_hit;

    // one strobe qualified by one register index, shared by logic and checks
    function automatic logic reg_hit
    (
        input logic                  strobe,
        input logic [CIE_ADDR_W-1:0] addr,
        input logic [3:0]            ofs
    );
        return strobe && (addr == ofs);
    endfunction : reg_hit

    assign wr_flags_hit   = reg_hit(i_wr, i_addr, CIE_OFS_FLAGS);     // [R17]
    assign wr_enables_hit = reg_hit(i_wr, i_addr, CIE_OFS_ENABLES);   // [R13]

    // ------------------------------------------------------------
    // live error state
    // ------------------------------------------------------------
    logic [5:0] err_bits;
    logic [5:0] err_bits_r;
    logic [7:0] tx_cnt_r;
    logic [7:0] rx_cnt_r;

    always_comb
    begin
        err_bits[CIE_BIT_TX_BO]   = i_err_state.tx_bus_off;   // [R1] [R19]
        err_bits[CIE_BIT_TX_BP]   = i_err_state.tx_passive;   // [R2]
        err_bits[CIE_BIT_RX_BP]   = i_err_state.rx_passive;   // [R3]
        err_bits[CIE_BIT_TX_WAR]  = i_err_state.tx_warning;   // [R4]
        err_bits[CIE_BIT_RX_WAR]  = i_err_state.rx_warning;   // [R5]
        err_bits[CIE_BIT_ANY_WAR] = i_err_state.tx_warning
                                  | i_err_state.rx_warning;   // [R6]
    end

    // registered so the read value and the error edge see the same sample
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            err_bits_r <= 6'h00;
        end
        else
        begin
            err_bits_r <= err_bits;                           // [R19]
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            tx_cnt_r <= CIE_RESET_CNT;
            rx_cnt_r <= CIE_RESET_CNT;
        end
        else
        begin
            tx_cnt_r <= i_tx_error_counter;                   // [R15]
            rx_cnt_r <= i_rx_error_counter;                   // [R16]
        end
    end

    // ------------------------------------------------------------
    // sticky flags
    // ------------------------------------------------------------
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;
    logic [7:0] set_vec;
    logic [7:0] clr_vec;
    logic       err_rise;

    // error flag fires on any newly entered error state, not on a held one
    assign err_rise = |(err_bits & ~err_bits_r);              // [R7]

    always_comb
    begin
        set_vec = i_events;                                   // [R8] [R9] [R10] [R11] [R12]
        set_vec[CIE_BIT_ERROR] = err_rise;                    // [R7]
        set_vec = set_vec & CIE_EVENT_MASK;                   // [R14]
        clr_vec = wr_flags_hit ? i_wdata[7:0] : 8'h00;        // [R17]
        flags_nxt = ((flags_r & ~clr_vec) | set_vec) & CIE_EVENT_MASK; // [R17]
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            flags_r <= CIE_RESET_LOW;
        end
        else
        begin
            flags_r <= flags_nxt;                             // [R17]
        end
    end

    // ------------------------------------------------------------
    // enables
    // ------------------------------------------------------------
    logic [7:0] enables_r;

    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            enables_r <= CIE_RESET_LOW;                       // [R13]
        end
        else if (wr_enables_hit)
        begin
            enables_r <= i_wdata[7:0] & CIE_EVENT_MASK;       // [R13] [R14]
        end
    end

    // ------------------------------------------------------------
    // interrupt and read port
    // ------------------------------------------------------------
    assign o_irq = |(flags_r & enables_r);                    // [R18]

    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            o_rdata <= 16'h0000;
        end
        else if (i_rd)
        begin
            unique case (i_addr)
                CIE_OFS_FLAGS:   o_rdata <= {2'h0, err_bits_r, flags_r};   // [R14]
                CIE_OFS_ENABLES: o_rdata <= {8'h00, enables_r};            // [R14]
                CIE_OFS_ERRCNT:  o_rdata <= {tx_cnt_r, rx_cnt_r};          // [R15] [R16]
                default:         o_rdata <= 16'h0000;
            endcase
        end
        else
        begin
            o_rdata <= 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_irq_follows_flags: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R18]
        $rose(o_irq) |-> ($past(set_vec) != 8'h00) || $past(wr_enables_hit))
        else $error("irq rose with no flag event or enable write");

    a_flag_set_wins: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R17]
        i_events.tx_buffer |=> flags_r[0])
        else $error("tx buffer flag lost");

    a_flag_sticks: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R17]
        (flags_r[1] && !(i_wr && i_addr == CIE_OFS_FLAGS && i_wdata[1])) |=> flags_r[1])
        else $error("rx buffer flag dropped without clear");

    a_bus_off_live: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R1]
        i_err_state.tx_bus_off |=> err_bits_r[CIE_BIT_TX_BO])
        else $error("bus off status not shown");

    a_warn_combined: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R6]
        $past(i_rstn) |-> err_bits_r[CIE_BIT_ANY_WAR]
            == ($past(i_err_state.tx_warning) | $past(i_err_state.rx_warning)))
        else $error("combined warning wrong");

    a_error_flag_rise: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R7]
        (i_err_state.rx_passive && !err_bits_r[CIE_BIT_RX_BP]) |=> flags_r[CIE_BIT_ERROR])
        else $error("error flag not raised");

    a_bit4_zero: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R14]
        !flags_r[4] && !enables_r[4])
        else $error("bit 4 set");

    a_count_read: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R15]
        (i_rd && i_addr == CIE_OFS_ERRCNT) |=> o_rdata == {$past(tx_cnt_r), $past(rx_cnt_r)})
        else $error("error count read wrong");

    a_enable_reset: assert property (@(posedge i_clock) // [R13]
        !i_rstn |=> enables_r == CIE_RESET_LOW)
        else $error("enables not cleared by reset");

    a_count_reset: assert property (@(posedge i_clock) // [R15] [R16]
        !i_rstn |=> (tx_cnt_r == CIE_RESET_CNT) && (rx_cnt_r == CIE_RESET_CNT))
        else $error("error counts not cleared by reset");

    a_flags_reset: assert property (@(posedge i_clock) // [R17]
        !i_rstn |=> (flags_r == CIE_RESET_LOW) && (o_rdata == 16'h0000))
        else $error("flags or read data not cleared by reset");

    // error state follows the engine one sample late, never latched
    a_tx_passive_live: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R2]
        $past(i_rstn) |-> err_bits_r[CIE_BIT_TX_BP] == $past(i_err_state.tx_passive))
        else $error("tx passive status wrong");

    a_rx_passive_live: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R3]
        $past(i_rstn) |-> err_bits_r[CIE_BIT_RX_BP] == $past(i_err_state.rx_passive))
        else $error("rx passive status wrong");

    a_tx_warn_live: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R4]
        $past(i_rstn) |-> err_bits_r[CIE_BIT_TX_WAR] == $past(i_err_state.tx_warning))
        else $error("tx warning status wrong");

    a_rx_warn_live: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R5]
        $past(i_rstn) |-> err_bits_r[CIE_BIT_RX_WAR] == $past(i_err_state.rx_warning))
        else $error("rx warning status wrong");

    a_bus_off_drop: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R19]
        !i_err_state.tx_bus_off |=> !err_bits_r[CIE_BIT_TX_BO])
        else $error("bus off status latched");

    // event flags
    a_bad_msg_flag: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R8]
        i_events.bad_message |=> flags_r[7])
        else $error("bad message flag not set");

    a_wakeup_flag: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R9]
        i_events.wakeup |=> flags_r[6])
        else $error("wake-up flag not set");

    a_queue_flag: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R10]
        i_events.queue_almost_full |=> flags_r[3])
        else $error("queue almost full flag not set");

    a_overflow_flag: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R11]
        i_events.rx_overflow |=> flags_r[2])
        else $error("rx overflow flag not set");

    a_rx_buf_flag: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R12]
        i_events.rx_buffer |=> flags_r[1])
        else $error("rx buffer flag not set");

    a_error_flag_cause: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R7]
        $rose(flags_r[CIE_BIT_ERROR]) |-> $past(err_rise))
        else $error("error flag set with no new error state");

    // a stray pulse on the error slot must not fake an error state
    a_event_bit5_ignored: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R7]
        (i_events.unused_error && !err_rise && !flags_r[CIE_BIT_ERROR])
            |=> !flags_r[CIE_BIT_ERROR])
        else $error("error flag set by event pulse");

    a_flag_clear: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R17]
        (wr_flags_hit && i_wdata[0] && !i_events.tx_buffer) |=> !flags_r[0])
        else $error("tx buffer flag not cleared");

    a_flag_no_phantom: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R17]
        (!flags_r[2] && !i_events.rx_overflow) |=> !flags_r[2])
        else $error("rx overflow flag set with no event");

    // enables
    a_enable_write: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R13]
        wr_enables_hit |=> {8'h00, enables_r} == ({8'h00, CIE_EVENT_MASK} & $past(i_wdata)))
        else $error("enable write not taken");

    a_enable_hold: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R13]
        !wr_enables_hit |=> $stable(enables_r))
        else $error("enables changed without write");

    // read port answers one cycle late, so the checks look one sample back
    a_flag_top_zero: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R14]
        reg_hit(i_rd, i_addr, CIE_OFS_FLAGS) |=> (o_rdata[15:14] == 2'h0) && !o_rdata[4])
        else $error("flag register reserved bits set");

    a_enable_upper_zero: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R14]
        reg_hit(i_rd, i_addr, CIE_OFS_ENABLES) |=> (o_rdata[15:8] == 8'h00) && !o_rdata[4])
        else $error("enable register reserved bits set");

    a_unmapped_zero: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R14]
        (i_rd && (i_addr > CIE_OFS_ERRCNT)) |=> o_rdata == 16'h0000)
        else $error("unmapped read not zero");

    a_idle_read_zero: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R14]
        !i_rd |=> o_rdata == 16'h0000)
        else $error("read data without read strobe");

    a_flags_read: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R17]
        reg_hit(i_rd, i_addr, CIE_OFS_FLAGS) |=> o_rdata[7:0] == $past(flags_r))
        else $error("flag read wrong");

    a_state_read: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R19]
        reg_hit(i_rd, i_addr, CIE_OFS_FLAGS) |=> o_rdata[13:8] == $past(err_bits_r))
        else $error("error state read wrong");

    a_enables_read: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R13]
        reg_hit(i_rd, i_addr, CIE_OFS_ENABLES) |=> o_rdata[7:0] == $past(enables_r))
        else $error("enable read wrong");

    a_tx_count_read: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R15]
        (reg_hit(i_rd, i_addr, CIE_OFS_ERRCNT) && $past(i_rstn))
            |=> o_rdata[15:8] == $past(i_tx_error_counter, 2))
        else $error("tx error count read wrong");

    a_rx_count_read: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R16]
        (reg_hit(i_rd, i_addr, CIE_OFS_ERRCNT) && $past(i_rstn))
            |=> o_rdata[7:0] == $past(i_rx_error_counter, 2))
        else $error("rx error count read wrong");

    // interrupt
    a_irq_event_path: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R18]
        (i_events.tx_buffer && enables_r[0] && !wr_enables_hit) |=> o_irq)
        else $error("enabled event gave no interrupt");

    a_irq_drop: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R18]
        (wr_enables_hit && (i_wdata[7:0] == 8'h00)) |=> !o_irq)
        else $error("interrupt with all enables off");

endmodule : cie_ctrl

/* File: include/cie_pkg.sv */
// package for the interrupt flag / enable / error count block
// assumes one 10 MHz clock and a plain strobe register port
package cie_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int          CIE_ADDR_W      = 4;
    localparam logic [3:0]  CIE_OFS_FLAGS   = 4'h0;
    localparam logic [3:0]  CIE_OFS_ENABLES = 4'h1;
    localparam logic [3:0]  CIE_OFS_ERRCNT  = 4'h2;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam logic [7:0]  CIE_EVENT_MASK  = 8'hEF;
    localparam logic [7:0]  CIE_RESET_LOW   = 8'h00;
    localparam logic [7:0]  CIE_RESET_CNT   = 8'h00;
    localparam int          CIE_BIT_ERROR   = 5;
    localparam int          CIE_BIT_TX_BO   = 5;
    localparam int          CIE_BIT_TX_BP   = 4;
    localparam int          CIE_BIT_RX_BP   = 3;
    localparam int          CIE_BIT_TX_WAR  = 2;
    localparam int          CIE_BIT_RX_WAR  = 1;
    localparam int          CIE_BIT_ANY_WAR = 0;

    // events from the protocol engine, one-cycle pulses
    typedef struct packed {
        logic bad_message;
        logic wakeup;
        logic unused_error;
        logic reserved;
        logic queue_almost_full;
        logic rx_overflow;
        logic rx_buffer;
        logic tx_buffer;
    } cie_events_t;

    // error state levels from the protocol engine
    typedef struct packed {
        logic tx_bus_off;
        logic tx_passive;
        logic rx_passive;
        logic tx_warning;
        logic rx_warning;
    } cie_err_state_t;

endpackage : cie_pkg

/* File: test/cie_engine_model.sv */
// protocol engine stand-in: event pulses, error levels, counters
// assumes the bench changes its commands right after rising edges
`timescale 1ns/1ps
module cie_engine_model
    import cie_pkg::*;
(
    // commands from the bench
    input  wire logic [7:0]         i_fire,
    input  wire logic [4:0]         i_state,
    input  wire logic [15:0]        i_counts,
    // towards the design
    output cie_pkg::cie_events_t    o_events,
    output cie_pkg::cie_err_state_t o_err_state,
    output logic      [15:0]        o_counts
);
    // events pass as one-cycle pulses; bits 5 and 4 are sent too, unkindly
    assign o_events    = cie_events_t'(i_fire);
    assign o_err_state = cie_err_state_t'(i_state);
    assign o_counts    = i_counts;
endmodule : cie_engine_model

/* File: test/can_interrupt_error_status_tb_top.sv */
// self-checking bench for the flag, enable and error count block
// assumes a 10 MHz clock and the one-cycle strobe register port
`timescale 1ns/1ps
module can_interrupt_error_status_tb_top;
    import cie_pkg::*;
    logic           i_clock = 0, i_rstn = 0, i_wr = 0, i_rd = 0, o_irq;
    logic [3:0]     i_addr  = '0;
    logic [15:0]    i_wdata = '0, cnt = '0, cw, o_rdata;
    logic [7:0]     fire    = '0;
    logic [4:0]     st      = '0;
    cie_events_t    ev;
    cie_err_state_t es;
    int             failures = 0, num_checks = 0, flags = 0, en = 0;

    always #50 i_clock = ~i_clock;

    cie_engine_model eng (.i_fire(fire), .i_state(st), .i_counts(cnt),
        .o_events(ev), .o_err_state(es), .o_counts(cw));
    cie_ctrl uut (.i_clock(i_clock), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_events(ev), .i_err_state(es),
        .i_tx_error_counter(cw[15:8]), .i_rx_error_counter(cw[7:0]), .o_irq(o_irq));

    // ----------------------------------------------------------------
    // model and compares
    // ----------------------------------------------------------------
    function automatic int hi();
        return {st, st[1] | st[0]};
    endfunction : hi

    task automatic chk_data(input logic [15:0] got, input int exp);
        num_checks++;
        if (got !== exp[15:0])
        begin
            failures++;
            $display("mismatch at %0t: read %h expected %h", $time, got, exp[15:0]);
        end
    endtask : chk_data

    task automatic chk_irq(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: irq %b expected %b", $time, got, exp);
        end
    endtask : chk_irq

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clock);
        i_wr <= 1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 0;
        if (a == 0) flags = flags & ~d[7:0];
        if (a == 1) en = d & 16'h00EF;
    endtask : wr

    task automatic rd(input logic [3:0] a, input int exp);
        @(posedge i_clock);
        i_rd <= 1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 0;
        #1 chk_data(o_rdata, exp);
    endtask : rd

    // a newly entered error state raises the error flag
    task automatic set_state(input logic [4:0] v);
        int old;
        old = hi();
        @(posedge i_clock);
        st <= v;
        #1 if ((hi() & ~old) != 0) flags |= 32;
        repeat (2) @(posedge i_clock);
    endtask : set_state

    task automatic wrap_up();
        if (failures == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : wrap_up

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial
    begin
        void'($urandom(70));
        repeat (10) @(posedge i_clock);
        i_rstn <= 1;
        rd(0, 0);
        rd(1, 0);
        rd(2, 0);
        for (int i = 0; i < 80; i++)
        begin
            case ($urandom_range(4))
                0: begin
                    @(posedge i_clock);
                    fire <= $urandom;
                    #1 flags |= fire & 8'hCF;
                    @(posedge i_clock);
                    fire <= 0;
                end
                1: set_state($urandom);
                2: begin
                    @(posedge i_clock);
                    cnt <= $urandom;
                    @(posedge i_clock);
                end
                3: wr($urandom_range(1), $urandom);
                default: wr($urandom_range(15, 2), $urandom);
            endcase
            rd(0, hi() << 8 | flags);
            rd(1, en);
            rd(2, cnt);
            rd($urandom_range(15, 3), 0);
            chk_irq(o_irq, (flags & en) != 0);
        end
        // clear and a new event in the same cycle: the event survives
        @(posedge i_clock);
        fire <= 8'h01;
        i_wr <= 1;
        i_addr <= 0;
        i_wdata <= 16'h00FF;
        @(posedge i_clock);
        fire <= 0;
        i_wr <= 0;
        flags = 1;
        rd(0, hi() << 8 | flags);
        wrap_up();
    end

    initial
    begin
        #2000000;
        failures++;
        wrap_up();
    end
endmodule : can_interrupt_error_status_tb_top
